/* design/fbsp_pkg.sv */
// Package for the fieldbus start-up master: telegram layout, register map,
// service codes and master states.
// Assumes a single 100 MHz clock domain and a byte-wide telegram link.
package fbsp_pkg;

  // ************************************************************
  // Telegram layout
  // ************************************************************
  localparam int          PRM_MAX_BYTES  = 244;
  localparam int          PRM_LEN        = 8;
  localparam logic [2:0]  PRM_LAST_IDX   = 3'h7;
  localparam int          STAT_WD_BIT    = 3;
  localparam int          STAT_FRZ_BIT   = 4;
  localparam int          STAT_LOCK_LO   = 6;
  localparam logic [7:0]  MIN_TSDR_LO    = 8'h0B;
  // Arbitrary neutral identification code expected of the slave.
  localparam logic [15:0] SLAVE_IDENT    = 16'h1234;

  // ************************************************************
  // Service codes sent on the link
  // ************************************************************
  localparam logic [2:0] SVC_DIAG   = 3'h1;
  localparam logic [2:0] SVC_PRM    = 3'h2;
  localparam logic [2:0] SVC_CHK    = 3'h3;
  localparam logic [2:0] SVC_GETCFG = 3'h4;
  localparam logic [2:0] SVC_WRRD   = 3'h5;
  localparam logic [2:0] SVC_RDIN   = 3'h6;
  localparam logic [2:0] SVC_RDOUT  = 3'h7;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_PRM_LO  = 5'h04;
  localparam logic [4:0] REG_PRM_HI  = 5'h08;
  localparam logic [4:0] REG_STATUS  = 5'h0C;
  localparam logic [4:0] REG_DATA    = 5'h10;
  localparam logic [4:0] REG_RESP    = 5'h14;
  localparam logic [31:0] PRM_LO_RST = 32'h000B0000;
  localparam logic [31:0] PRM_HI_RST = 32'h00003412;
  localparam logic [1:0]  AXI_OKAY   = 2'h0;
  localparam logic [1:0]  AXI_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    FBSP_IDLE, FBSP_DIAG1, FBSP_PRM_SEND, FBSP_PRM_WAIT,
    FBSP_CHK, FBSP_DIAG2, FBSP_RUN, FBSP_XCHG, FBSP_FAIL
  } fbsp_state_e;

  // One request toward the slave.
  typedef struct packed {
    logic       valid;
    logic [2:0] svc;
    logic       last;
    logic [7:0] data;
  } fbsp_req_s;

  // One answer from the slave.
  typedef struct packed {
    logic       valid;
    logic       ok;
    logic       diag_pending;
    logic [7:0] data;
  } fbsp_rsp_s;

endpackage

/* design/fbsp_master.sv */
// Fieldbus start-up master: drives the slave through diagnosis,
// parameterisation, configuration check and into cyclic exchange.
// Assumes the slave answers every request, possibly several clocks later; software
// reaches the controller over AXI4-Lite.
//
// What this block does
// - Open start-up with a diagnostic request confirming the slave is present.
// - Send the parameter telegram next; wait for its error-free confirmation.
// - Then issue the configuration check and await its acknowledgement.
// - Then ask by diagnostic request whether parameters and configuration pass.
// - Start cyclic write-read exchange only after both were accepted.
// - A parameter telegram never exceeds 244 bytes.
// - Send exactly eight parameter bytes, byte 7 vendor-specific, in one go.
// - Bit 7 of each byte is its most significant bit.
// - Bytes 1,2 are watchdog factors; byte 3 minimum response time, 11 up.
// - Bytes 4 and 5 carry the slave identification number, high first.
// - Byte 0 is station status and byte 6 group assignment.
// - Station status bit 4 is always sent as one.
// - Station status bits 6 and 7 are sent as software wrote them.
`timescale 1ns/1ps
module fbsp_master
  import fbsp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output fbsp_req_s        req,
  input  wire logic        req_ready,
  input  fbsp_rsp_s        rsp
);

  // ************************************************************
  // Registers and state
  // ************************************************************
  fbsp_state_e state_q, state_d;
  logic [31:0] prm_lo_q, prm_hi_q;
  logic [2:0]  idx_q;
  logic [2:0]  svc_q;
  logic        start_q, xchg_go_q, prm_err_q, diag_note_q;
  logic [7:0]  tx_q, rx_q, resp_q;
  logic        aw_q, w_q;
  logic [4:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  fbsp_req_s   req_q;

  // Parameter byte picker, used for sending and for checks.
  function automatic logic [7:0] prm_byte(input logic [2:0] i,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
    logic [63:0] all;
    all = {hi, lo};
    prm_byte = all[{i, 3'h0} +: 8];
  endfunction

  // ************************************************************
  // Telegram assembly and checks
  // ************************************************************
  // Status byte forces freeze support; bits 6..7 come from software.
  wire logic [7:0] stat_raw  = prm_byte(3'h0, prm_lo_q, prm_hi_q);
  wire logic [7:0] stat_byte = stat_raw | (8'h01 << STAT_FRZ_BIT);
  wire logic [7:0] tsdr      = prm_byte(3'h3, prm_lo_q, prm_hi_q);
  wire logic [15:0] ident    = {prm_byte(3'h4, prm_lo_q, prm_hi_q),
                                prm_byte(3'h5, prm_lo_q, prm_hi_q)};
  wire logic       prm_bad   = (tsdr < MIN_TSDR_LO) ||
                               (ident != SLAVE_IDENT);
  // Byte 0 uses the forced status, the rest go out as written, MSB at 7.
  wire logic [7:0] cur_byte  = (idx_q == 3'h0) ? stat_byte :
                               prm_byte(idx_q, prm_lo_q, prm_hi_q);
  wire logic       wd_en     = stat_byte[STAT_WD_BIT];
  wire logic [1:0] master_lk = stat_byte[STAT_LOCK_LO +: 2];
  wire logic       rsp_ok    = rsp.valid && rsp.ok;
  wire logic       rsp_bad   = rsp.valid && !rsp.ok;

  // ************************************************************
  // Start-up sequencer
  // ************************************************************
  // Each stage waits for its answer; the slave cannot be rushed.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      FBSP_IDLE:     if (start_q && !prm_bad) state_d = FBSP_DIAG1;
      FBSP_DIAG1:    if (rsp_ok) state_d = FBSP_PRM_SEND;
                     else if (rsp_bad) state_d = FBSP_FAIL;
      FBSP_PRM_SEND: if (req_ready && idx_q == PRM_LAST_IDX)
                       state_d = FBSP_PRM_WAIT;
      FBSP_PRM_WAIT: if (rsp_ok) state_d = FBSP_CHK;
                     else if (rsp_bad) state_d = FBSP_FAIL;
      FBSP_CHK:      if (rsp_ok) state_d = FBSP_DIAG2;
                     else if (rsp_bad) state_d = FBSP_FAIL;
      FBSP_DIAG2:    if (rsp_ok) state_d = FBSP_RUN;
                     else if (rsp_bad) state_d = FBSP_FAIL;
      FBSP_RUN:      if (xchg_go_q) state_d = FBSP_XCHG;
      FBSP_XCHG:     if (rsp_bad) state_d = FBSP_FAIL;
                     else if (rsp.valid) state_d = FBSP_RUN;
      FBSP_FAIL:     if (start_q) state_d = FBSP_IDLE;
    endcase
  end

  // Request channel: one request is offered at a time and held, payload
  // and all, until the slave takes it. A byte the slave holds off must not
  // move on, or the telegram would silently lose that byte.
  wire logic       taken    = req_q.valid && req_ready;
  wire logic       enter    = (state_d != state_q);
  wire logic [2:0] idx_nx   = idx_q + 3'h1;
  wire logic       prm_next = (state_q == FBSP_PRM_SEND) && taken &&
                              (idx_q != PRM_LAST_IDX);
  wire logic       stage_req = state_d inside {FBSP_DIAG1, FBSP_PRM_SEND,
                                               FBSP_CHK, FBSP_DIAG2,
                                               FBSP_XCHG};
  wire logic [2:0] stage_svc =
    (state_d == FBSP_PRM_SEND) ? SVC_PRM :
    (state_d == FBSP_CHK)      ? SVC_CHK :
    (state_d == FBSP_XCHG)     ? svc_q   : SVC_DIAG;

  // A new stage loads a fresh request; inside the burst a take loads the
  // next byte, so the index and the byte on the link always agree.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= FBSP_IDLE;
      idx_q   <= 3'h0;
      req_q   <= '0;
    end else begin
      state_q <= state_d;
      if (state_q != FBSP_PRM_SEND) begin
        idx_q <= 3'h0;
      end else if (taken) begin
        idx_q <= idx_nx;
      end
      if (taken) begin
        req_q.valid <= 1'b0;
      end
      if (enter) begin
        req_q.valid <= stage_req;
        req_q.svc   <= stage_svc;
        req_q.last  <= (state_d != FBSP_PRM_SEND);
        req_q.data  <= (state_d == FBSP_PRM_SEND) ? stat_byte : tx_q;
      end else if (prm_next) begin
        req_q.valid <= 1'b1;
        req_q.last  <= (idx_nx == PRM_LAST_IDX);
        req_q.data  <= prm_byte(idx_nx, prm_lo_q, prm_hi_q);
      end
    end
  end
  assign req = req_q;

  // Slave answers and unsolicited diagnostic notices.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_q        <= 8'h00;
      prm_err_q   <= 1'b0;
      diag_note_q <= 1'b0;
    end else begin
      if (rsp.valid) begin
        rx_q <= rsp.data;
      end
      if (rsp_bad) begin
        prm_err_q <= 1'b1;
      end else if (state_q == FBSP_IDLE && start_q) begin
        prm_err_q <= 1'b0;
      end
      // Set wins over the software clear.
      if (rsp.valid && rsp.diag_pending && state_q >= FBSP_PRM_SEND) begin
        diag_note_q <= 1'b1;
      end else if (w_q && aw_q && awaddr_q == REG_STATUS) begin
        diag_note_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************
  wire logic wr_fire = aw_q && w_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_q;
  assign s_axi_wready  = !w_q;
  assign s_axi_arready = !s_axi_rvalid;
  wire logic wr_map = awaddr_q inside {REG_CTRL, REG_PRM_LO, REG_PRM_HI,
                                       REG_STATUS, REG_DATA};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; awaddr_q <= 5'h00;
      wdata_q <= 32'h0; wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= AXI_OKAY;
      prm_lo_q <= PRM_LO_RST; prm_hi_q <= PRM_HI_RST;
      start_q <= 1'b0; xchg_go_q <= 1'b0;
      svc_q <= SVC_WRRD; tx_q <= 8'h00;
    end else begin
      start_q   <= 1'b0;
      xchg_go_q <= 1'b0;
      if (s_axi_awvalid && !aw_q) begin
        aw_q <= 1'b1; awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q) begin
        w_q <= 1'b1; wdata_q <= s_axi_wdata; wstrb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_fire) begin
        aw_q <= 1'b0; w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? AXI_OKAY : AXI_SLVERR;
        if (awaddr_q == REG_CTRL && wstrb_q[0]) begin
          start_q   <= wdata_q[0];
          xchg_go_q <= wdata_q[1];
          // Requests 4..7 are only honoured in the data phase.
          if (wdata_q[6:4] inside {SVC_GETCFG, SVC_WRRD, SVC_RDIN,
                                   SVC_RDOUT})
            svc_q <= wdata_q[6:4];
        end
        if (awaddr_q == REG_PRM_LO) begin
          for (int b = 0; b < 4; b++)
            if (wstrb_q[b]) prm_lo_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
        end
        if (awaddr_q == REG_PRM_HI) begin
          for (int b = 0; b < 4; b++)
            if (wstrb_q[b]) prm_hi_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
        end
        if (awaddr_q == REG_DATA && wstrb_q[0]) begin
          tx_q <= wdata_q[7:0];
        end
      end
    end
  end

  // Read mux; the status word shows the sequencer's own state.
  wire logic [31:0] status_w = {16'h0, 8'(PRM_LEN), 1'b0, wd_en,
                                master_lk, diag_note_q, prm_err_q,
                                (state_q == FBSP_RUN), 1'b0} |
                               {28'h0, state_q} << 24;
  wire logic rd_map = s_axi_araddr inside {REG_CTRL, REG_PRM_LO, REG_PRM_HI,
                                           REG_STATUS, REG_DATA, REG_RESP};
  wire logic [31:0] rd_w =
    (s_axi_araddr == REG_CTRL)   ? {25'h0, svc_q, 4'h0} :
    (s_axi_araddr == REG_PRM_LO) ? prm_lo_q :
    (s_axi_araddr == REG_PRM_HI) ? prm_hi_q :
    (s_axi_araddr == REG_STATUS) ? status_w :
    (s_axi_araddr == REG_DATA)   ? {24'h0, tx_q} :
    (s_axi_araddr == REG_RESP)   ? {24'h0, rx_q} : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= AXI_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_w;
      s_axi_rresp  <= rd_map ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Helper for the length check: bytes the slave has taken in the current
  // burst. Counting takes rather than cycles keeps the check true however
  // often the slave holds off.
  logic [3:0] ast_sent_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q != FBSP_PRM_SEND) begin
      ast_sent_q <= 4'h0;
    end else if (req.valid && req_ready) begin
      ast_sent_q <= ast_sent_q + 4'h1;
    end
  end

  // The burst ends with its last take and the wait for confirmation.
  sequence prm_left;
    (state_q == FBSP_PRM_SEND) ##1 (state_q == FBSP_PRM_WAIT);
  endsequence

  AST_FRZ_BIT: assert property (
    req.valid && req.svc == SVC_PRM && idx_q == 3'h0 && state_q ==
    FBSP_PRM_SEND |-> req.data[STAT_FRZ_BIT])
    else $error("status byte sent without freeze bit");
  AST_XCHG_AFTER_OK: assert property (
    state_q == FBSP_XCHG |-> $past(state_q) inside {FBSP_RUN, FBSP_XCHG})
    else $error("exchange entered before acceptance");
  AST_FAIL_BLOCKS: assert property (
    state_q == FBSP_FAIL && !start_q |=> state_q == FBSP_FAIL)
    else $error("left failure without restart");
  AST_REJECT: assert property (
    state_q == FBSP_DIAG2 && rsp_bad |=> state_q == FBSP_FAIL)
    else $error("rejection not honoured");
  AST_PRM_ORDER: assert property (
    $rose(state_q == FBSP_PRM_SEND) |-> $past(state_q) == FBSP_DIAG1)
    else $error("parameters sent before diagnosis");
  AST_CHK_ORDER: assert property (
    $rose(state_q == FBSP_CHK) |-> $past(state_q) == FBSP_PRM_WAIT)
    else $error("check before parameter confirm");
  AST_DIAG2_ORDER: assert property (
    $rose(state_q == FBSP_DIAG2) |-> $past(state_q) == FBSP_CHK)
    else $error("accept query out of order");
  AST_OPEN: assert property (
    $rose(state_q == FBSP_DIAG1) |-> $past(state_q) == FBSP_IDLE)
    else $error("start-up not opened by diagnosis");
  AST_LEN: assert property (
    prm_left |-> ast_sent_q == 4'(PRM_LEN))
    else $error("parameter telegram not eight bytes");
  AST_START_OK: assert property (
    state_q == FBSP_IDLE && start_q && prm_bad |=> state_q == FBSP_IDLE)
    else $error("bad parameters sent");
  AST_PRM_BYTE: assert property (
    state_q == FBSP_PRM_SEND && req.valid |-> req.data == cur_byte)
    else $error("parameter byte out of step with its index");
  AST_HOLD: assert property (
    req.valid && !req_ready |=>
      req.valid && $stable(req.data) && $stable(req.svc))
    else $error("request changed before it was taken");
  AST_IDLE_QUIET: assert property (
    state_q == FBSP_IDLE |-> !req.valid)
    else $error("request offered before start-up");
  AST_RUN_QUIET: assert property (
    state_q == FBSP_RUN |-> !req.valid)
    else $error("request offered without exchange order");

endmodule

/* testbench/fbsp_slave_model.sv */
// Behavioural fieldbus slave facing the start-up master's link port.
// Assumes the master's clock and its synchronous active-low reset.
`timescale 1ns/1ps
module fbsp_slave_model
  import fbsp_pkg::*;
#(
  parameter logic [7:0] CFG_ID = 8'h41
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  fbsp_req_s req,
  output logic      req_ready,
  output fbsp_rsp_s rsp,
  input  wire logic cfg_bad,
  input  wire logic notice
);
  // ************************************************************
  // Request intake and delayed answers
  // ************************************************************
  logic [7:0] prm [0:7];
  logic [3:0] idx, tick;
  logic [2:0] wait_q;
  logic       pend, ok_q, seen;
  logic [7:0] dat_q;
  // Watchdog enable and timeout span from the bytes.
  wire        wd_en   = prm[0][STAT_WD_BIT];
  wire [17:0] wd_span = prm[1] * prm[2] * (prm[7][1:0] + 3'h1);
  wire        take    = req.valid && req_ready;
  // The telegram is checked when its last byte arrives, seven stored.
  wire        prm_ok  = idx == 4'h7 && prm[3] >= MIN_TSDR_LO &&
                        prm[0][STAT_FRZ_BIT] && {prm[4], prm[5]} == SLAVE_IDENT;
  // A mismatched island refuses the query and data services 5..7, but not the configuration fetch.
  wire        dsvc    = req.svc inside {SVC_WRRD, SVC_RDIN, SVC_RDOUT};
  wire        refuse  = cfg_bad && seen && (dsvc || req.svc == SVC_DIAG);
  // Stalls and answer delays vary so both slow and prompt paths run.
  always @(posedge aclk) begin
    if (!aresetn) begin
      {req_ready, pend, seen, idx, tick, wait_q} <= '0;
      rsp <= '0;
    end else begin
      tick      <= tick + 4'h1;
      req_ready <= tick[1:0] != 2'h3;
      rsp       <= '0;
      if (take && req.svc == SVC_PRM) begin
        prm[idx[2:0]] <= req.data;
        idx           <= idx + 4'h1;
      end
      if (take && (req.svc != SVC_PRM || req.last)) begin
        pend   <= 1'b1;
        wait_q <= tick[2:0];
        ok_q   <= req.svc == SVC_PRM ? prm_ok : !refuse;
        dat_q  <= req.svc == SVC_GETCFG ? CFG_ID : req.data + 8'h01;
      end
      if (pend && wait_q == 3'h0) begin
        pend <= 1'b0;
        seen <= 1'b1;
        rsp  <= '{1'b1, ok_q, notice && seen, dat_q};
      end else if (pend) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule

/* testbench/fbsp_master_tb.sv */
// Self-checking bench: AXI4-Lite software side against a model slave.
// Assumes the package constants and a 100 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module fbsp_master_tb;
  import fbsp_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, req_ready;
  logic        cfg_bad, notice;
  logic [4:0]  awaddr, araddr;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  logic [31:0] wdata, rdata, d, lo, hi, x;
  fbsp_req_s   req;
  fbsp_rsp_s   rsp;
  fbsp_req_s   log_q[$];
  int          n_errors, compares, n_rsp, seed, k;
  fbsp_master u_fbsp_master (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .req(req),
    .req_ready(req_ready), .rsp(rsp));
  fbsp_slave_model u_fbsp_slave_model (.aclk(aclk), .aresetn(aresetn),
    .req(req), .req_ready(req_ready), .rsp(rsp), .cfg_bad(cfg_bad),
    .notice(notice));
  // ************************************************************
  // Clock, monitors and bus tasks
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Every request the slave takes is logged for order checks.
  always @(posedge aclk) begin
    if (req.valid && req_ready) log_q.push_back(req);
    if (rsp.valid) n_rsp++;
  end
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rr = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d  = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  // Reset is held six cycles; the log restarts with it.
  task automatic rst();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    log_q.delete();
  endtask
  // Polling is cut short only by the watchdog below.
  task automatic wait_status(input logic [31:0] m);
    do rd(REG_STATUS); while ((d & m) == 32'h0);
  endtask
  // Byte i of the telegram as sent, with the freeze bit forced on.
  function automatic logic [7:0] pbyte(input int i);
    logic [63:0] all;
    all = {hi, lo};
    pbyte = all[8*i +: 8] | (i == 0 ? 8'h10 : 8'h00);
  endfunction
  // Watchdog span the slave should derive: factor 1 x factor 2 x base.
  function automatic logic [17:0] wd_exp();
    wd_exp = {10'h0, lo[15:8]} * {10'h0, lo[23:16]} *
             ({16'h0, hi[25:24]} + 18'h1);
  endfunction
  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // The whole run needs a few hundred cycles; this is far beyond.
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    seed = 32'hde9e1f30;
    {awvalid, wvalid, bready, arvalid, rready, cfg_bad, notice} = '0;
    {awaddr, araddr, wdata, wstrb, aresetn} = {42'h0, 4'hF, 1'b0};
    rst();
    rd(REG_PRM_LO); `CHK(d, PRM_LO_RST)
    rd(REG_PRM_HI); `CHK(d, PRM_HI_RST)
    // Only the lowest lane enabled: the other three bytes must stay.
    wstrb <= 4'h1;
    wr(REG_PRM_HI, 32'hFFFFFF56);
    wstrb <= 4'hF;
    rd(REG_PRM_HI); `CHK(d, {PRM_HI_RST[31:8], 8'h56})
    rd(5'h18); `CHK({rr, d}, {AXI_SLVERR, 32'h0})
    wr(5'h1C, 32'h1); `CHK(rr, AXI_SLVERR)
    // Minimum response time of ten with the identity still 0x5634, then identity 0x1235 alone: no start.
    wr(REG_PRM_LO, 32'h0A000000);
    wr(REG_CTRL, 32'h1);
    repeat (30) @(posedge aclk);
    `CHK(log_q.size(), 0)
    wr(REG_PRM_LO, 32'h0B000000);
    wr(REG_PRM_HI, 32'h00003512);
    wr(REG_CTRL, 32'h1);
    repeat (30) @(posedge aclk);
    `CHK(log_q.size(), 0)
    // Full start-up with random factors and status bits.
    rst();
    x  = $random(seed);
    lo = {8'h0B + x[7:0] % 8'hF5, x[31:16], x[9], x[8] ^ x[0], x[5:0]};
    lo[4] = 1'b0;
    x  = $random(seed);
    hi = {x[15:0], SLAVE_IDENT[7:0], SLAVE_IDENT[15:8]};
    wr(REG_PRM_LO, lo);
    wr(REG_PRM_HI, hi);
    wr(REG_CTRL, 32'h1);
    wait_status(32'h6);
    `CHK(d & 32'h0F00FF7E, {4'h0, 4'(FBSP_RUN), 16'h0008, 1'b0, lo[3], lo[7:6], 4'h2})
    `CHK(u_fbsp_slave_model.wd_en, lo[3])
    `CHK(u_fbsp_slave_model.wd_span, wd_exp())
    `CHK(log_q.size(), 11)
    `CHK(log_q[0].svc, SVC_DIAG)
    for (int i = 0; i < 8; i++) begin
      `CHK(log_q[1+i], {1'b1, SVC_PRM, (i == 7), pbyte(i)})
    end
    `CHK(log_q[9].svc, SVC_CHK)
    `CHK(log_q[10].svc, SVC_DIAG)
    // Every data service in turn; the slave flags a notice on the last.
    for (int s = 4; s < 8; s++) begin
      notice <= (s == 7);
      x = $random(seed);
      wr(REG_DATA, {24'h0, x[7:0]});
      k = n_rsp;
      wr(REG_CTRL, {25'h0, 3'(s), 4'h2});
      while (n_rsp < k + 1) @(posedge aclk);
      `CHK({log_q[log_q.size()-1].svc, log_q[log_q.size()-1].data}, {3'(s), x[7:0]})
      rd(REG_RESP);
      `CHK(d[7:0], s == 4 ? 8'h41 : x[7:0] + 8'h01)
    end
    notice <= 1'b0;
    rd(REG_STATUS); `CHK(d[3], 1'b1)
    wr(REG_STATUS, 32'h0);
    rd(REG_STATUS); `CHK(d[3], 1'b0)
    // Island mismatch: rejection, then data exchange stays shut.
    rst();
    cfg_bad <= 1'b1;
    wr(REG_PRM_LO, lo);
    wr(REG_PRM_HI, hi);
    wr(REG_CTRL, 32'h1);
    wait_status(32'h6);
    `CHK(d[2:1], 2'b10)
    k = log_q.size();
    wr(REG_CTRL, 32'h52);
    repeat (30) @(posedge aclk);
    `CHK(log_q.size(), k)
    finish_test();
  end
endmodule
